//--- logic/gpoc_output_control.sv
// general-purpose output control register, pin drivers and serial shifter
`timescale 1ns/1ps
module gpoc_output_control #(
    parameter int unsigned REG_WIDTH = gpoc_pkg::REG_WIDTH
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [2:0] reg_sel_i,
    input wire logic xfer_start_i,
    input wire logic bit_strobe_i,
    input wire logic ser_din_i,
    input wire logic write_commit_i,
    output logic ser_dout_o,
    input wire logic reference_source_select_i,
    input wire logic [3:0] pin_in_i,
    output logic [3:0] pin_out_o,
    output logic [3:0] pin_oe_o,
    output logic upper_analog_route_o,
    output logic lower_analog_route_o,
    output logic second_reference_route_o,
    output logic [7:0] general_output_control_o
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (REG_WIDTH != gpoc_pkg::REG_WIDTH) begin : g_bad_width
        $error("register width must be eight");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic sel_hit(input logic [2:0] sel);
        sel_hit = (sel == gpoc_pkg::SEL_OUTPUT_CONTROL);
    endfunction : sel_hit

    // ------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------
    logic [3:0] pin_meta_r;
    logic [3:0] pin_sync_r;
    logic [3:0] pin_meta_nxt;
    logic [3:0] pin_sync_nxt;

    always_comb begin
        pin_meta_nxt = pin_in_i;
        pin_sync_nxt = pin_meta_r;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_meta_r <= 4'h0;
            pin_sync_r <= 4'h0;
        end else begin
            pin_meta_r <= pin_meta_nxt;
            pin_sync_r <= pin_sync_nxt;
        end
    end

    // ------------------------------------------------------------
    // control register and serial shifter
    // ------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] readback;
    logic upper_en;
    logic lower_en;

    assign upper_en = ctrl_r[gpoc_pkg::BIT_UPPER_PAIR_ENABLE];
    assign lower_en = ctrl_r[gpoc_pkg::BIT_LOWER_PAIR_ENABLE];

    always_comb begin
        readback = ctrl_r;
        // an enabled pair reports the pin, so a shorted pin shows up on read
        if (upper_en) begin
            readback[3:2] = pin_sync_r[3:2]; // see RQ12
        end
        if (lower_en) begin
            readback[1:0] = pin_sync_r[1:0]; // see RQ13
        end
        // a disabled pair keeps ctrl_r bits, i.e. the last written data (see RQ16)
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        shift_nxt = shift_r;
        if (xfer_start_i) begin
            shift_nxt = sel_hit(reg_sel_i) ? readback : 8'h00;
        end else if (bit_strobe_i) begin
            shift_nxt = {shift_r[6:0], ser_din_i}; // see RQ15
        end
        // top bits are stored as written; host keeps them zero (see RQ1)
        if (write_commit_i && sel_hit(reg_sel_i)) begin
            ctrl_nxt = shift_r; // see RQ14
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r <= gpoc_pkg::OUTPUT_CONTROL_RESET; // see RQ14
            shift_r <= 8'h00;
        end else begin
            ctrl_r <= ctrl_nxt;
            shift_r <= shift_nxt;
        end
    end

    assign ser_dout_o = shift_r[gpoc_pkg::SERIAL_FIRST_BIT]; // see RQ15
    assign general_output_control_o = ctrl_r;

    // ------------------------------------------------------------
    // pin drivers and analog routing
    // ------------------------------------------------------------
    logic [3:0] pin_out_r;
    logic [3:0] pin_oe_r;
    logic [3:0] pin_out_nxt;
    logic [3:0] pin_oe_nxt;
    logic upper_analog_r;
    logic lower_analog_r;
    logic second_ref_r;
    logic upper_analog_nxt;
    logic lower_analog_nxt;
    logic second_ref_nxt;

    always_comb begin
        pin_oe_nxt = {{2{upper_en}}, {2{lower_en}}}; // see RQ2, see RQ4
        pin_out_nxt = 4'h0;
        if (upper_en) begin
            pin_out_nxt[3] = ctrl_r[gpoc_pkg::BIT_VALUE_THREE]; // see RQ8
            pin_out_nxt[2] = ctrl_r[gpoc_pkg::BIT_VALUE_TWO]; // see RQ9
        end
        // disabled lower pair floats and its data bits are ignored (see RQ5)
        if (lower_en) begin
            pin_out_nxt[1] = ctrl_r[gpoc_pkg::BIT_VALUE_ONE]; // see RQ10
            pin_out_nxt[0] = ctrl_r[gpoc_pkg::BIT_VALUE_ZERO]; // see RQ11
        end
        upper_analog_nxt = !upper_en; // see RQ3
        second_ref_nxt = !lower_en && reference_source_select_i; // see RQ6
        lower_analog_nxt = !lower_en && !reference_source_select_i; // see RQ7
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_out_r <= 4'h0;
            pin_oe_r <= 4'h0;
            upper_analog_r <= 1'b1;
            lower_analog_r <= 1'b1;
            second_ref_r <= 1'b0;
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            upper_analog_r <= upper_analog_nxt;
            lower_analog_r <= lower_analog_nxt;
            second_ref_r <= second_ref_nxt;
        end
    end

    assign pin_out_o = pin_out_r;
    assign pin_oe_o = pin_oe_r;
    assign upper_analog_route_o = upper_analog_r;
    assign lower_analog_route_o = lower_analog_r;
    assign second_reference_route_o = second_ref_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_read_start;
        xfer_start_i && sel_hit(reg_sel_i);
    endsequence

    sequence s_write;
        write_commit_i && sel_hit(reg_sel_i);
    endsequence

    property p_upper_release;
        !upper_en |=> pin_oe_o[3:2] == 2'h0 && pin_out_o[3:2] == 2'h0 && upper_analog_route_o;
    endproperty

    property p_lower_drive;
        lower_en |=> pin_oe_o[1:0] == 2'h3 && !second_reference_route_o;
    endproperty

    property p_lower_float;
        !lower_en |=> pin_oe_o[1:0] == 2'h0 && pin_out_o[1:0] == 2'h0;
    endproperty

    property p_second_ref;
        !lower_en && reference_source_select_i |=>
            second_reference_route_o && !lower_analog_route_o;
    endproperty

    property p_analog_low;
        !lower_en && !reference_source_select_i |=>
            lower_analog_route_o && !second_reference_route_o;
    endproperty

    property p_read_upper;
        s_read_start ##0 upper_en |=> shift_r[3:2] == $past(pin_sync_r[3:2]);
    endproperty

    property p_read_lower;
        s_read_start ##0 lower_en |=> shift_r[1:0] == $past(pin_sync_r[1:0]);
    endproperty

    property p_msb_first;
        s_read_start ##1 !xfer_start_i && bit_strobe_i |-> ##1 ser_dout_o == $past(shift_r[6]);
    endproperty

    property p_read_held_upper;
        s_read_start ##0 !upper_en |=> shift_r[3:2] == $past(ctrl_r[3:2]);
    endproperty

    property p_read_held_lower;
        s_read_start ##0 !lower_en |=> shift_r[1:0] == $past(ctrl_r[1:0]);
    endproperty

    // a foreign select must neither leak this register nor overwrite it
    property p_other_read;
        xfer_start_i && !sel_hit(reg_sel_i) |=> shift_r == 8'h00;
    endproperty

    property p_other_write;
        write_commit_i && !sel_hit(reg_sel_i) |=> $stable(ctrl_r);
    endproperty

    AST_UPPER_DRIVE: assert property (upper_en |=> pin_oe_o[3:2] == 2'h3) // see RQ2
        else $error("upper pair not driven while enabled");
    AST_UPPER_RELEASE: assert property (p_upper_release) // see RQ3
        else $error("upper pair driven while disabled");
    AST_LOWER_DRIVE: assert property (p_lower_drive) // see RQ4
        else $error("lower pair not driven while enabled");
    AST_LOWER_FLOAT: assert property (p_lower_float) // see RQ5
        else $error("lower pair not floating while disabled");
    AST_SECOND_REF: assert property (p_second_ref) // see RQ6
        else $error("second reference not routed");
    AST_ANALOG_LOW: assert property (p_analog_low) // see RQ7
        else $error("analog three and four not routed");
    AST_PIN_THREE: assert property (upper_en |=> pin_out_o[3] == $past(ctrl_r[3])) // see RQ8
        else $error("pin three does not follow its data bit");
    AST_PIN_TWO: assert property (upper_en |=> pin_out_o[2] == $past(ctrl_r[2])) // see RQ9
        else $error("pin two does not follow its data bit");
    AST_PIN_ONE: assert property (lower_en |=> pin_out_o[1] == $past(ctrl_r[1])) // see RQ10
        else $error("pin one does not follow its data bit");
    AST_PIN_ZERO: assert property (lower_en |=> pin_out_o[0] == $past(ctrl_r[0])) // see RQ11
        else $error("pin zero does not follow its data bit");
    AST_READ_UPPER: assert property (p_read_upper) // see RQ12
        else $error("upper readback is not the pin level");
    AST_READ_LOWER: assert property (p_read_lower) // see RQ13
        else $error("lower readback is not the pin level");
    AST_WRITE: assert property (s_write |=> ctrl_r == $past(shift_r)) // see RQ14
        else $error("write did not land in the control register");
    AST_OTHER_READ: assert property (p_other_read) // see RQ14
        else $error("foreign select read returned register data");
    AST_OTHER_WRITE: assert property (p_other_write) // see RQ14
        else $error("foreign select write changed the register");
    AST_MSB_FIRST: assert property (p_msb_first) // see RQ15
        else $error("serial order is not most significant first");
    AST_READ_HELD: assert property (p_read_held_upper) // see RQ16
        else $error("disabled pair does not read back written data");
    AST_READ_HELD_LOWER: assert property (p_read_held_lower) // see RQ16
        else $error("disabled lower pair does not read back written data");

endmodule : gpoc_output_control

//--- logic/gpoc_pkg.sv
// constants and register layout for the general-purpose output control block
// What this block does
// RQ1: host keeps the two top bits zero
// RQ2: upper enable set drives pins three and two
// RQ3: upper enable clear releases pins to analog
// RQ4: lower enable set drives pins one and zero
// RQ5: lower enable clear floats pins, ignores data
// RQ6: lower off, reference select set: second reference
// RQ7: lower off, reference select clear: analog three/four
// RQ8: pin three follows data bit three
// RQ9: pin two follows data bit two
// RQ10: pin one follows data bit one
// RQ11: pin zero follows data bit zero
// RQ12: upper enabled read returns pin levels
// RQ13: lower enabled read returns pin levels
// RQ14: 8-bit register, select 101, resets zero
// RQ15: most significant bit travels first
// RQ16: disabled pair reads back written data
package gpoc_pkg;
    localparam int unsigned REG_WIDTH = 8;
    localparam int unsigned SEL_WIDTH = 3;
    localparam int unsigned PIN_COUNT = 4;
    localparam logic [2:0] SEL_OUTPUT_CONTROL = 3'h5;
    localparam logic [7:0] OUTPUT_CONTROL_RESET = 8'h00;
    localparam int unsigned BIT_RESERVED_HI = 7;
    localparam int unsigned BIT_RESERVED_LO = 6;
    localparam int unsigned BIT_UPPER_PAIR_ENABLE = 5;
    localparam int unsigned BIT_LOWER_PAIR_ENABLE = 4;
    localparam int unsigned BIT_VALUE_THREE = 3;
    localparam int unsigned BIT_VALUE_TWO = 2;
    localparam int unsigned BIT_VALUE_ONE = 1;
    localparam int unsigned BIT_VALUE_ZERO = 0;
    localparam int unsigned SERIAL_FIRST_BIT = REG_WIDTH - 1;
endpackage : gpoc_pkg

//--- verif/general_purpose_output_control_tb.sv
// self-checking testbench for the output control block
`timescale 1ns/1ps
module general_purpose_output_control_tb;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [2:0] sel = 3'h0;
    logic xs = 1'b0, bs = 1'b0, sdin = 1'b0, wc = 1'b0, rsel = 1'b0, clash = 1'b0;
    logic sdout, ua, la, sr;
    logic [3:0] lvl, pout, poe;
    logic [7:0] ctl, rd;
    int err_total = 0;
    int compares = 0;
    always #4 clk_i = ~clk_i;
    gpoc_output_control gpoc_output_control_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .reg_sel_i(sel), .xfer_start_i(xs), .bit_strobe_i(bs), .ser_din_i(sdin),
        .write_commit_i(wc), .ser_dout_o(sdout), .reference_source_select_i(rsel),
        .pin_in_i(lvl), .pin_out_o(pout), .pin_oe_o(poe), .upper_analog_route_o(ua),
        .lower_analog_route_o(la), .second_reference_route_o(sr),
        .general_output_control_o(ctl));
    gpoc_pad_model gpoc_pad_model_i (.pin_out_i(pout), .pin_oe_i(poe),
        .clash_i(clash), .pin_lvl_o(lvl));
    task automatic results();
        $display("compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // load readback, shift 8 bits msb first both ways, then optionally commit
    task automatic xfer(input logic [2:0] s, input logic [7:0] wd, input logic cm,
                        output logic [7:0] r);
        @(posedge clk_i);
        sel <= s;
        xs <= 1'b1;
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_i);
            xs <= 1'b0;
            bs <= 1'b1;
            sdin <= wd[i];
            @(negedge clk_i);
            r[i] = sdout;
        end
        @(posedge clk_i);
        bs <= 1'b0;
        wc <= cm;
        @(posedge clk_i);
        wc <= 1'b0;
    endtask : xfer
    task automatic wr_chk(input logic [7:0] wd, input logic [3:0] oe, input logic [3:0] po,
                          input logic [2:0] rt, input logic [7:0] exp_rd);
        logic [7:0] r;
        xfer(3'h5, wd, 1'b1, r);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk(ctl, wd);
        chk({4'h0, poe}, {4'h0, oe});
        chk({4'h0, pout}, {4'h0, po});
        chk({5'h0, ua, la, sr}, {5'h0, rt});
        xfer(3'h5, 8'h00, 1'b0, r);
        chk(r, exp_rd);
        $display("test write %h done", wd);
    endtask : wr_chk
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        results();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(negedge clk_i);
        chk(ctl, 8'h00);
        chk({4'h0, poe}, 8'h00);
        chk({5'h0, ua, la, sr}, 8'h06);
        xfer(3'h5, 8'h00, 1'b0, rd);
        chk(rd, 8'h00);
        $display("test reset done");
        // top two bits are always written as zero
        wr_chk(8'h3A, 4'hF, 4'hA, 3'b000, 8'h3A);
        wr_chk(8'h35, 4'hF, 4'h5, 3'b000, 8'h35);
        rsel <= 1'b1;
        wr_chk(8'h25, 4'hC, 4'h4, 3'b001, 8'h25);
        rsel <= 1'b0;
        wr_chk(8'h1A, 4'h3, 4'h2, 3'b100, 8'h1A);
        wr_chk(8'h00, 4'h0, 4'h0, 3'b110, 8'h00);
        xfer(3'h3, 8'h2F, 1'b1, rd);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk(rd, 8'h00);
        chk(ctl, 8'h00);
        $display("test other select done");
        // shorted pins must show in readback, not the stored data
        clash <= 1'b1;
        wr_chk(8'h3A, 4'hF, 4'hA, 3'b000, 8'h35);
        // a reset in mid-run must clear a written register and release the pins
        clash <= 1'b0;
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(negedge clk_i);
        chk(ctl, 8'h00);
        chk({4'h0, poe}, 8'h00);
        chk({4'h0, pout}, 8'h00);
        chk({5'h0, ua, la, sr}, 8'h06);
        xfer(3'h5, 8'h00, 1'b0, rd);
        chk(rd, 8'h00);
        $display("test mid-run reset done");
        results();
    end
endmodule : general_purpose_output_control_tb

//--- verif/gpoc_pad_model.sv
// pad and external circuitry model for the four general-purpose pins
`timescale 1ns/1ps
module gpoc_pad_model (
    input wire logic [3:0] pin_out_i,
    input wire logic [3:0] pin_oe_i,
    input wire logic clash_i,
    output logic [3:0] pin_lvl_o
);
    // an undriven pin settles opposite to the held drive value, so a readback
    // that wrongly samples a released pin shows up as a mismatch
    // clash_i models an external short that overpowers the driver
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_lvl_o[i] = pin_oe_i[i] ? (pin_out_i[i] ^ clash_i) : ~pin_out_i[i];
        end
    end
endmodule : gpoc_pad_model
